// >>> hw/sbpm_pkg.sv
// Purpose: Constants for the protection bit map table block.
// Assumes: Classic Wishbone slave, 32-bit data, word index addressing.
// Notes:   Byte address of a register is four times its index.
// What this block does
// - Index 257H returns FCH, section 3 end.
// - Index 258H returns 03H, section 4 type.
// - Index 259H returns 00H, one 32K block.
// - Index 25AH returns FEH, section 4 start.
// - Index 25BH returns FEH, section 4 end.
// - Index 25CH returns 02H, section 5 type.
// - Index 25DH returns 02H, section 5 count.
// - Index 25EH returns 07H, section 5 start.
// - Index 25FH returns 0EH, section 5 end.
// - Section word: type, count, start, end bytes.
// - Sector type codes are 01H through 04H.
// - Uniform 4K sectors get no section entry.
package sbpm_pkg;

	// ------------------------------------------------------------
	// Table indices and contents
	// ------------------------------------------------------------
	localparam logic [9:0] IDX_S3_END   = 10'h257;
	localparam logic [9:0] IDX_S4_TYPE  = 10'h258;
	localparam logic [9:0] IDX_S4_COUNT = 10'h259;
	localparam logic [9:0] IDX_S4_START = 10'h25A;
	localparam logic [9:0] IDX_S4_END   = 10'h25B;
	localparam logic [9:0] IDX_S5_TYPE  = 10'h25C;
	localparam logic [9:0] IDX_S5_COUNT = 10'h25D;
	localparam logic [9:0] IDX_S5_START = 10'h25E;
	localparam logic [9:0] IDX_S5_END   = 10'h25F;
	localparam logic [9:0] TBL_BASE     = 10'h257;
	localparam int         TBL_LEN      = 9;

	localparam logic [7:0] VAL_S3_END   = 8'hFC;
	localparam logic [7:0] VAL_S4_TYPE  = 8'h03;
	localparam logic [7:0] VAL_S4_COUNT = 8'h00;
	localparam logic [7:0] VAL_S4_START = 8'hFE;
	localparam logic [7:0] VAL_S4_END   = 8'hFE;
	localparam logic [7:0] VAL_S5_TYPE  = 8'h02;
	localparam logic [7:0] VAL_S5_COUNT = 8'h02;
	localparam logic [7:0] VAL_S5_START = 8'h07;
	localparam logic [7:0] VAL_S5_END   = 8'h0E;

	// ------------------------------------------------------------
	// Extra registers, sector codes, density
	// ------------------------------------------------------------
	localparam logic [9:0] IDX_S4_WORD  = 10'h260;
	localparam logic [9:0] IDX_S5_WORD  = 10'h261;
	localparam logic [9:0] IDX_CTRL     = 10'h262;
	localparam logic [9:0] IDX_DEC3     = 10'h263;
	localparam logic [9:0] IDX_DEC4     = 10'h264;
	localparam logic [9:0] IDX_DEC5     = 10'h265;
	localparam logic [9:0] IDX_STATUS   = 10'h266;

	localparam logic [7:0] SECT_TYPE_MIN = 8'h01;
	localparam logic [7:0] SECT_TYPE_MAX = 8'h04;
	localparam logic [3:0] M_RST         = 4'h7;
	localparam logic [3:0] M_MIN         = 4'h4;
	localparam logic [3:0] M_MAX         = 4'h8;
	localparam logic [8:0] QUERY_RST     = 9'h000;
	localparam logic [7:0] REFUSED_RST   = 8'h00;
	localparam logic [7:0] REFUSED_MAX   = 8'hFF;

endpackage

// >>> hw/sbpm_rom.sv
// Purpose: Constant byte table with registered read data.
// Assumes: Address stable in the cycle before data is used.
// Notes:   No write port exists, so contents cannot change.
`timescale 1ns/1ps
module sbpm_rom
	import sbpm_pkg::*;
#(
	parameter int W     = 8,
	parameter int DEPTH = TBL_LEN,
	parameter int AW    = 4
) (
	input  wire logic          clock,
	input  wire logic [AW-1:0] addr,
	output logic      [W-1:0]  rdata_r
);

	// ------------------------------------------------------------
	// Contents
	// ------------------------------------------------------------
	function automatic logic [7:0] entry(input logic [AW-1:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (int'(a) < DEPTH) begin
			unique case (int'(a))
				0: v = VAL_S3_END;
				1: v = VAL_S4_TYPE;
				2: v = VAL_S4_COUNT;
				3: v = VAL_S4_START;
				4: v = VAL_S4_END;
				5: v = VAL_S5_TYPE;
				6: v = VAL_S5_COUNT;
				7: v = VAL_S5_START;
				8: v = VAL_S5_END;
				default: v = 8'h00;
			endcase
		end
		return v;
	endfunction

	// Read data registered; no write path at all
	always_ff @(posedge clock) begin
		rdata_r <= W'(entry(addr));
	end

endmodule

// >>> hw/sbpm_top.sv
// Purpose: Wishbone slave exposing the protection bit map table.
// Assumes: Classic single cycle master holding requests until ack.
// Notes:   Every access is acked one edge after it is taken.
`timescale 1ns/1ps
module sbpm_top
	import sbpm_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Location of a start/end byte for density m
	function automatic logic [9:0] loc(input logic [7:0] c,
		input logic [3:0] m);
		logic [9:0] base;
		base = (10'h001 << m) + 10'h001;
		if (c == 8'h00)
			return 10'h000;
		return base + {{2{c[7]}}, c};
	endfunction

	// Sector count field to number of blocks
	function automatic logic [9:0] cnt(input logic [7:0] n);
		return (n < 8'h09) ? (10'h001 << n[3:0]) : 10'h000;
	endfunction

	// Whether a code names a listed sector type
	function automatic logic type_ok(input logic [7:0] t);
		return (t >= SECT_TYPE_MIN) && (t <= SECT_TYPE_MAX);
	endfunction

	// ------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------
	logic [9:0]  idx;
	logic        req;
	logic        busy_r;
	logic        we_r;
	logic [9:0]  idx_r;
	logic [3:0]  sel_r;
	logic [31:0] dat_r;
	logic [7:0]  rom_q;
	logic        tbl_hit;
	logic [3:0]  rom_addr;

	assign idx      = wb_adr_i[11:2];
	// Guard on ack stops a held request being taken twice
	assign req      = wb_cyc_i & wb_stb_i & ~busy_r & ~wb_ack_o;
	assign tbl_hit  = (idx >= TBL_BASE) &&
		(idx < TBL_BASE + 10'(TBL_LEN));
	assign rom_addr = tbl_hit ? 4'(idx - TBL_BASE) : 4'hF;

	// Byte table, read on the same edge the request is taken
	sbpm_rom #(
		.W     (8),
		.DEPTH (TBL_LEN),
		.AW    (4)
	) u_rom (
		.clock   (clock),
		.addr    (rom_addr),
		.rdata_r (rom_q)
	);

	// Capture the request
	always_ff @(posedge clock) begin
		if (rst) begin
			busy_r <= 1'b0;
			we_r   <= 1'b0;
			idx_r  <= 10'h000;
			sel_r  <= 4'h0;
			dat_r  <= 32'h0000_0000;
		end else if (req) begin
			busy_r <= 1'b1;
			we_r   <= wb_we_i;
			idx_r  <= idx;
			sel_r  <= wb_sel_i;
			dat_r  <= wb_dat_i;
		end else begin
			busy_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Control: density and lock query
	// ------------------------------------------------------------
	logic       wr_now;
	logic [3:0] m_r;
	logic [8:0] query_r;
	logic [3:0] m_nxt;

	assign wr_now = busy_r & we_r;
	assign m_nxt  = dat_r[3:0];

	// Density written only when inside the supported span
	always_ff @(posedge clock) begin
		if (rst) begin
			m_r     <= M_RST;
			query_r <= QUERY_RST;
		end else if (wr_now && idx_r == IDX_CTRL) begin
			if (sel_r[0] && m_nxt >= M_MIN && m_nxt <= M_MAX)
				m_r <= m_nxt;
			if (sel_r[2])
				query_r[7:0] <= dat_r[23:16];
			if (sel_r[3])
				query_r[8] <= dat_r[24];
		end
	end

	// Writes anywhere else are refused and counted
	logic [7:0] refused_r;
	always_ff @(posedge clock) begin
		if (rst)
			refused_r <= REFUSED_RST;
		else if (wr_now && idx_r != IDX_CTRL &&
			refused_r != REFUSED_MAX)
			refused_r <= refused_r + 8'h01;
	end

	// ------------------------------------------------------------
	// Decoded locations, recomputed for the current density
	// ------------------------------------------------------------
	logic [9:0] s3_end_r;
	logic [9:0] s4_start_r;
	logic [9:0] s4_end_r;
	logic [9:0] s5_start_r;
	logic [9:0] s5_end_r;
	logic [9:0] blk64_r;
	logic       span_ok_r;
	logic [2:0] qres_r;
	logic [9:0] span4;
	logic [9:0] span5;

	// Locations per section; each section a separate unit
	always_ff @(posedge clock) begin
		if (rst) begin
			s3_end_r   <= 10'h000;
			s4_start_r <= 10'h000;
			s4_end_r   <= 10'h000;
			s5_start_r <= 10'h000;
			s5_end_r   <= 10'h000;
			blk64_r    <= 10'h000;
		end else begin
			s3_end_r   <= loc(VAL_S3_END, m_r);
			s4_start_r <= loc(VAL_S4_START, m_r);
			s4_end_r   <= loc(VAL_S4_END, m_r);
			s5_start_r <= loc(VAL_S5_START, m_r);
			s5_end_r   <= loc(VAL_S5_END, m_r);
			blk64_r    <= (10'h001 << m_r) - 10'h002;
		end
	end

	// One location per step; section 4 span must match its count
	assign span4 = s4_end_r - s4_start_r + 10'h001;
	assign span5 = s5_end_r - s5_start_r + 10'h001;

	always_ff @(posedge clock) begin
		if (rst)
			span_ok_r <= 1'b0;
		else
			span_ok_r <= (span4 == cnt(VAL_S4_COUNT)) &&
				type_ok(VAL_S4_TYPE) && type_ok(VAL_S5_TYPE);
	end

	// Parameter block lock kind of the queried location
	always_ff @(posedge clock) begin
		if (rst) begin
			qres_r <= 3'b000;
		end else begin
			qres_r[0] <= ({1'b0, query_r} >= s5_start_r) &&
				({1'b0, query_r} <= s5_end_r);
			qres_r[1] <= ~query_r[0];
			qres_r[2] <= query_r[0];
		end
	end

	// ------------------------------------------------------------
	// Read mux and answer
	// ------------------------------------------------------------
	logic [31:0] rd_nxt;
	logic [31:0] s4_word;
	logic [31:0] s5_word;

	// Type low, count, start, end high
	assign s4_word = {VAL_S4_END, VAL_S4_START, VAL_S4_COUNT,
		VAL_S4_TYPE};
	assign s5_word = {VAL_S5_END, VAL_S5_START, VAL_S5_COUNT,
		VAL_S5_TYPE};

	// Unmapped indices read zero; no 4K section entry
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (idx_r >= TBL_BASE && idx_r < TBL_BASE + 10'(TBL_LEN))
			rd_nxt = {24'h00_0000, rom_q};
		else if (idx_r == IDX_S4_WORD)
			rd_nxt = s4_word;
		else if (idx_r == IDX_S5_WORD)
			rd_nxt = s5_word;
		else if (idx_r == IDX_CTRL)
			rd_nxt = {7'h00, query_r, 12'h000, m_r};
		else if (idx_r == IDX_DEC3)
			rd_nxt = {6'h00, blk64_r, 6'h00, s3_end_r};
		else if (idx_r == IDX_DEC4)
			rd_nxt = {6'h00, s4_end_r, 6'h00, s4_start_r};
		else if (idx_r == IDX_DEC5)
			rd_nxt = {6'h00, s5_end_r, 6'h00, s5_start_r};
		else if (idx_r == IDX_STATUS)
			rd_nxt = {12'h000, span5[7:0], qres_r, span_ok_r,
				refused_r};
	end

	// Ack lasts one cycle; data held until the next answer
	always_ff @(posedge clock) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= busy_r;
			if (busy_r)
				wb_dat_o <= we_r ? 32'h0000_0000 : rd_nxt;
		end
	end

endmodule

// >>> tb/sbpm_properties.sv
// Purpose: Checker for bus timing and table contents of the slave.
// Assumes: Sees only the top module ports, one clock domain.
// Notes:   Bound into every sbpm_top instance.
`timescale 1ns/1ps
module sbpm_properties
	import sbpm_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// Request and answer steps
	// ------------------------------------------------------------
	sequence s_take;
		$rose(wb_cyc_i && wb_stb_i);
	endsequence
	sequence s_answer;
		!wb_ack_o ##1 wb_ack_o;
	endsequence
	sequence s_rd(logic [9:0] idx);
		wb_ack_o && !wb_we_i && wb_adr_i[11:2] == idx;
	endsequence
	// Timing of every access, held to the fixed latency
	a_ack_two_edges: assert property (s_take |=> s_answer)
		else $error("ack not two edges after request");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_has_cause: assert property
		(wb_ack_o |-> $past(wb_cyc_i && wb_stb_i, 2))
		else $error("ack without a request");
	a_write_ack_zero: assert property
		(wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
		else $error("write ack carries data");
	// Reset must silence the bus, so no disable here
	a_reset_quiet: assert property (disable iff (1'b0)
		rst |=> !wb_ack_o && wb_dat_o == 32'h0)
		else $error("bus active in reset");
	// Table bytes, exact figures
	a_s3_end_byte: assert property
		(s_rd(IDX_S3_END) |-> wb_dat_o == 32'h000000FC)
		else $error("section 3 end byte wrong");
	a_s4_start_byte: assert property
		(s_rd(IDX_S4_START) |-> wb_dat_o == 32'h000000FE)
		else $error("section 4 start byte wrong");
	a_s5_type_byte: assert property
		(s_rd(IDX_S5_TYPE) |-> wb_dat_o == 32'h00000002)
		else $error("section 5 type byte wrong");
	a_s4_word_pack: assert property
		(s_rd(IDX_S4_WORD) |-> wb_dat_o == 32'hFEFE0003)
		else $error("section 4 word wrong");
	a_s5_word_pack: assert property
		(s_rd(IDX_S5_WORD) |-> wb_dat_o == 32'h0E070202)
		else $error("section 5 word wrong");
endmodule
bind sbpm_top sbpm_properties i_sbpm_properties (.clock(clock),
	.rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// >>> tb/sbpm_host.sv
// Purpose: Host model doing classic Wishbone single cycles.
// Assumes: One access at a time; slave answers in bounded time.
// Notes:   Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
module sbpm_host (
	input  wire logic        clock,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic      [11:0] adr,
	output logic      [3:0]  sel,
	output logic      [31:0] dat,
	input  wire logic [31:0] rdat,
	input  wire logic        ack
);
	// Idle bus at time zero
	initial begin
		{cyc, stb, we, adr, sel, dat} = '0;
	end
	// One cycle; waits for ack, only the bench watchdog ends a hang
	task automatic xfer(input logic w, input logic [9:0] idx,
		input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clock);
		{cyc, stb, we, sel, dat} <= {2'b11, w, s, d};
		adr <= {idx, 2'b00};
		do begin
			@(posedge clock);
		end while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
		adr <= ~{idx, 2'b00};
		dat <= ~d;
	endtask
	// Location from an adder byte at density m
	function automatic logic [9:0] loc(input logic [7:0] c,
		input int m);
		return (c == 8'h00) ? 10'h000 :
			10'((2 ** m) + 1 + $signed(c));
	endfunction
endmodule

// >>> tb/sbpm_top_bench.sv
// Purpose: Self-checking bench for the protection map slave.
// Assumes: Host model issues every bus cycle.
// Notes:   Expected values come from the table below.
`timescale 1ns/1ps
module sbpm_top_bench
	import sbpm_pkg::*;
;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        cyc, stb, we, ack;
	logic [11:0] adr;
	logic [3:0]  sel;
	logic [31:0] dw, dr, q, r;
	logic [9:0]  idx, ql;
	logic [7:0]  tbl [9] = '{8'hFC, 8'h03, 8'h00, 8'hFE, 8'hFE,
		8'h02, 8'h02, 8'h07, 8'h0E};
	int          bad_count = 0;
	int          compares = 0;
	int          seed = 96685;
	int          refused = 0;
	int          mc = 7;
	// Free-running 100 MHz clock
	always #5 clock = ~clock;
	sbpm_host i_sbpm_host (.clock(clock), .cyc(cyc), .stb(stb),
		.we(we), .adr(adr), .sel(sel), .dat(dw), .rdat(dr), .ack(ack));
	sbpm_top i_sbpm_top (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack));
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic test_done();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Section word as type, count, start, end bytes
	function automatic logic [31:0] word(input int b);
		return {tbl[b+3], tbl[b+2], tbl[b+1], tbl[b]};
	endfunction
	// Location from table byte b at current density
	function automatic logic [9:0] lb(input int b);
		return i_sbpm_host.loc(tbl[b], mc);
	endfunction
	// Watchdog far beyond the expected run
	initial begin
		#100000;
		bad_count++;
		test_done();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		for (int i = 0; i < 9; i++) begin
			i_sbpm_host.xfer(1'b0, 10'h257 + 10'(i), 4'hF, 32'h0, q);
			chk("table", {24'h0, tbl[i]}, q);
		end
		i_sbpm_host.xfer(1'b0, 10'h260, 4'hF, 32'h0, q);
		chk("s4 word", word(1), q);
		i_sbpm_host.xfer(1'b0, 10'h261, 4'hF, 32'h0, q);
		chk("s5 word", word(5), q);
		$display("test reset values done");
		// Writes to read-only places, unmapped one included
		for (int k = 0; k < 7; k++) begin
			r = $random(seed);
			idx = (k == 0) ? 10'h100 : 10'h257 + 10'(r[31:28] % 9);
			i_sbpm_host.xfer(1'b1, idx, 4'hF, r, q);
			chk("write ack", 32'h0, q);
			refused++;
			i_sbpm_host.xfer(1'b0, idx, 4'hF, 32'h0, q);
			chk("reread", (k == 0) ? 32'h0 :
				{24'h0, tbl[idx - 10'h257]}, q);
		end
		$display("test read only done");
		// Every density, two refused values around them
		for (int m = 3; m <= 9; m++) begin
			i_sbpm_host.xfer(1'b1, 10'h262, 4'h1, 32'(m), q);
			if (m >= 4 && m <= 8)
				mc = m;
			repeat (3) @(posedge clock);
			i_sbpm_host.xfer(1'b0, 10'h263, 4'hF, 32'h0, q);
			chk("dec3", {6'h0, 10'((2 ** mc) - 2), 6'h0, lb(0)}, q);
			i_sbpm_host.xfer(1'b0, 10'h264, 4'hF, 32'h0, q);
			chk("dec4", {6'h0, lb(4), 6'h0, lb(3)}, q);
			i_sbpm_host.xfer(1'b0, 10'h265, 4'hF, 32'h0, q);
			chk("dec5", {6'h0, lb(8), 6'h0, lb(7)}, q);
			// Density read back; refused values leave it unchanged
			i_sbpm_host.xfer(1'b0, 10'h262, 4'hF, 32'h0, q);
			chk("ctrl m", {28'h0, 4'(mc)}, q);
		end
		$display("test density done");
		// Query edges of section 5, then random spots
		mc = 7;
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			ql = (k < 4) ? 10'(135 + (k / 2) * 8 + k % 2) : 10'(128 + r[4:0]);
			i_sbpm_host.xfer(1'b1, 10'h262, 4'hD,
				{7'h0, ql[8:0], 12'h0, 4'h7}, q);
			repeat (3) @(posedge clock);
			i_sbpm_host.xfer(1'b0, 10'h262, 4'hF, 32'h0, q);
			chk("ctrl q", {7'h0, ql[8:0], 12'h0, 4'h7}, q);
			i_sbpm_host.xfer(1'b0, 10'h266, 4'hF, 32'h0, q);
			chk("status", {12'h0, 8'h08, ql[0], !ql[0],
				ql >= 136 && ql <= 143, 1'b1, 8'(refused)}, q);
		end
		$display("test query done");
		test_done();
	end
endmodule
